// File: issm_bus_peer.sv
// Two-wire bus with pull-ups and a second master that frames it.
// Assumes open-drain ends: an enable high pulls its line low.
`timescale 1ns/1ps
`default_nettype none

module issm_bus_peer (
   // Design side
   input wire logic sda_oe,
   input wire logic scl_oe,
   // Line levels
   output logic sda,
   output logic scl
);
   logic p_sda_low = 1'b0;
   logic p_scl_low = 1'b0;

   // Wired AND with pull-ups, so a released line goes high
   assign sda = !(sda_oe || p_sda_low);
   assign scl = !(scl_oe || p_scl_low);

   // Half link period 80 ns, offset so no edge meets an aclk edge
   task start;
      #83 p_sda_low = 1'b1;
      #80 p_scl_low = 1'b1;
   endtask : start

   task stop;
      #83 p_scl_low = 1'b0;
      #80 p_sda_low = 1'b0;
   endtask : stop
endmodule : issm_bus_peer

`default_nettype wire

// File: issm_cond_gen.sv
// Start, repeated-start and stop sequencer for the two bus lines.
// Assumes one-cycle requests from issm_ctrl, never while gen_busy.
`timescale 1ns/1ps
`default_nettype none

module issm_cond_gen #(
   parameter int T_CYC = 470
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register side
   issm_cond_if.gen cif
);

   issm_pkg::issm_gen_state_t state;
   issm_pkg::issm_gen_state_t next_state;
   logic [15:0] cnt;
   wire tick = (cnt == 16'(T_CYC - 1));

   // ------------------------------------------------------------------
   // Step sequence
   // ------------------------------------------------------------------
   // A start first frees both lines, so the same walk serves a
   // repeated start from a held bus.
   always_comb begin
      next_state = state;
      case (state)
         issm_pkg::ST_IDLE: begin
            if (cif.start_req)
               next_state = issm_pkg::ST_S_REL_SDA;
            else if (cif.stop_req)
               next_state = issm_pkg::ST_P_SDA_LOW;
         end
         issm_pkg::ST_S_REL_SDA: if (tick) next_state = issm_pkg::ST_S_REL_SCL;
         issm_pkg::ST_S_REL_SCL: if (tick) next_state = issm_pkg::ST_S_SDA_LOW;
         issm_pkg::ST_S_SDA_LOW: if (tick) next_state = issm_pkg::ST_S_SCL_LOW;
         issm_pkg::ST_S_SCL_LOW: next_state = issm_pkg::ST_IDLE;
         issm_pkg::ST_P_SDA_LOW: if (tick) next_state = issm_pkg::ST_P_REL_SCL;
         issm_pkg::ST_P_REL_SCL: if (tick) next_state = issm_pkg::ST_P_REL_SDA;
         issm_pkg::ST_P_REL_SDA: next_state = issm_pkg::ST_IDLE;
         default: next_state = issm_pkg::ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // Line drive
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || cif.ctl_rst) begin
         state <= issm_pkg::ST_IDLE;
         cnt <= 16'h0000;
         cif.sda_low <= 1'b0;
         cif.scl_low <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= (next_state != state) ? 16'h0000 : cnt + 16'h0001;
         case (next_state)
            issm_pkg::ST_S_REL_SDA: cif.sda_low <= 1'b0;
            issm_pkg::ST_S_REL_SCL: cif.scl_low <= 1'b0;
            issm_pkg::ST_S_SDA_LOW: cif.sda_low <= 1'b1;
            issm_pkg::ST_S_SCL_LOW: cif.scl_low <= 1'b1;
            issm_pkg::ST_P_SDA_LOW: cif.sda_low <= 1'b1;
            issm_pkg::ST_P_REL_SCL: cif.scl_low <= 1'b0;
            issm_pkg::ST_P_REL_SDA: cif.sda_low <= 1'b0;
            default: ;
         endcase
      end
   end

   assign cif.gen_busy = (state != issm_pkg::ST_IDLE);

endmodule : issm_cond_gen

`default_nettype wire

// File: issm_cond_if.sv
// Carrier between the register side and the condition generator.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
`default_nettype none

interface issm_cond_if;
   logic start_req;
   logic stop_req;
   logic ctl_rst;
   logic gen_busy;
   logic sda_low;
   logic scl_low;

   modport ctrl (output start_req, output stop_req, output ctl_rst,
      input gen_busy, input sda_low, input scl_low);
   modport gen (input start_req, input stop_req, input ctl_rst,
      output gen_busy, output sda_low, output scl_low);
endinterface : issm_cond_if

`default_nettype wire

// File: issm_ctrl.sv
// Top of the start/stop condition and line monitor block: AXI4-Lite
// register slave, bus line watcher and condition issue control.
// Assumes open-drain pads outside: a line is pulled low while its
// output enable is high and floats high otherwise.
//
// Behaviour
// - Data line falling while clock line high sets the bus-occupied flag.
// - Data line rising while clock line high clears the bus-occupied flag.
// - Master mode, write busy=1 issue=0 issues start or repeated start.
// - Master mode, write busy=0 issue=0 issues a stop condition.
// - Condition issue only takes effect in master mode.
// - Issue bit reads 1; writing 1 is not stored and issues nothing.
// - Data monitor bit reads 0 while driving data low, else 1.
// - Clock monitor bit reads 0 while driving clock low, else 1.
// - Master and transmit select bits choose one of four modes.
// - Control module reset bit resets control logic and the busy flag, keeps other registers.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "issm_defs.svh"

module issm_ctrl #(
   parameter int T_COND_CYC = `ISSM_T_COND_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Data line, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Clock line, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe
);

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic busy_flag;
   logic rsvd4;
   logic cm_reset;
   issm_pkg::issm_mode_t mode;

   issm_cond_if cif ();

   // ------------------------------------------------------------------
   // Line synchronisers and condition watcher
   // ------------------------------------------------------------------
   logic sda_m;
   logic sda_s;
   logic sda_d;
   logic scl_m;
   logic scl_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
      end else begin
         sda_m <= sda_in;
         sda_s <= sda_m;
         scl_m <= scl_in;
         scl_s <= scl_m;
      end
   end

   // The previous-sample stage belongs to control logic, so a module
   // reset also drops it; that avoids a false edge at reset release.
   always_ff @(posedge aclk) begin
      if (!aresetn || cm_reset)
         sda_d <= 1'b1;
      else
         sda_d <= sda_s;
   end

   wire start_seen = sda_d & ~sda_s & scl_s;
   wire stop_seen = ~sda_d & sda_s & scl_s;

   // ------------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------------
   logic aw_have;
   logic w_have;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire wr_do = aw_have & w_have & ~s_axi_bvalid;
   wire b_done = s_axi_bvalid & s_axi_bready;

   wire next_aw_have = aw_fire | (aw_have & ~wr_do);
   wire next_w_have = w_fire | (w_have & ~wr_do);
   wire next_bvalid = wr_do | (s_axi_bvalid & ~b_done);

   wire wr_cond = (aw_addr == `ISSM_OFF_COND);
   wire wr_mode = (aw_addr == `ISSM_OFF_MODE);
   wire wr_hit = wr_cond | wr_mode;
   wire wr_cond_lane = wr_do & wr_cond & w_strb[0];
   wire wr_mode_lane = wr_do & wr_mode & w_strb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         if (aw_fire)
            aw_addr <= {s_axi_awaddr[11:2], 2'h0};
         if (w_fire) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ISSM_RESP_OKAY;
      end else begin
         s_axi_awready <= ~next_aw_have & ~next_bvalid;
         s_axi_wready <= ~next_w_have & ~next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (wr_do)
            s_axi_bresp <= wr_hit ? `ISSM_RESP_OKAY : `ISSM_RESP_SLVERR;
      end
   end

   // ------------------------------------------------------------------
   // Condition issue decode
   // ------------------------------------------------------------------
   // Busy and issue bits are taken from one write beat; a split
   // read-modify-write would see issue read back as 1 and do nothing.
   wire issue_low = ~w_data[`ISSM_BIT_ISSUE];
   wire in_master = (mode == issm_pkg::MODE_MST_RX) ||
      (mode == issm_pkg::MODE_MST_TX);
   wire issue_ok = wr_cond_lane & issue_low & in_master & ~cm_reset &
      ~cif.gen_busy;
   wire next_start = issue_ok & w_data[`ISSM_BIT_BUSY];
   wire next_stop = issue_ok & ~w_data[`ISSM_BIT_BUSY];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cif.start_req <= 1'b0;
         cif.stop_req <= 1'b0;
      end else begin
         cif.start_req <= next_start;
         cif.stop_req <= next_stop;
      end
   end

   assign cif.ctl_rst = cm_reset;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Monitor bits have no storage, so writes to them fall away.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsvd4 <= `ISSM_RST_RSVD4;
         cm_reset <= `ISSM_RST_CMRST;
         mode <= issm_pkg::issm_mode_t'(`ISSM_RST_MODE);
      end else begin
         if (wr_cond_lane) begin
            rsvd4 <= w_data[`ISSM_BIT_RSVD4];
            cm_reset <= w_data[`ISSM_BIT_CMRST];
         end
         if (wr_mode_lane)
            mode <= issm_pkg::issm_mode_t'(
               {w_data[`ISSM_BIT_MST], w_data[`ISSM_BIT_TRS]});
      end
   end

   // The flag follows the bus itself, so it also tracks other
   // masters; a start in the same cycle as a stop cannot occur.
   always_ff @(posedge aclk) begin
      if (!aresetn || cm_reset)
         busy_flag <= 1'b0;
      else if (start_seen)
         busy_flag <= 1'b1;
      else if (stop_seen)
         busy_flag <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         scl_out <= 1'b0;
         sda_oe <= cif.sda_low;
         scl_oe <= cif.scl_low;
      end
   end

   // ------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire r_done = s_axi_rvalid & s_axi_rready;
   wire next_rvalid = ar_fire | (s_axi_rvalid & ~r_done);
   wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'h0};
   wire rd_cond = (rd_addr == `ISSM_OFF_COND);
   wire rd_mode = (rd_addr == `ISSM_OFF_MODE);

   logic [7:0] cond_view;
   logic [7:0] mode_view;

   always_comb begin
      cond_view = 8'h00;
      cond_view[`ISSM_BIT_BUSY] = busy_flag;
      cond_view[`ISSM_BIT_ISSUE] = `ISSM_RD_ISSUE;
      cond_view[`ISSM_BIT_SDAMON] = ~sda_oe;
      cond_view[`ISSM_BIT_RSVD4] = rsvd4;
      cond_view[`ISSM_BIT_SCLMON] = ~scl_oe;
      cond_view[`ISSM_BIT_RSVD2] = `ISSM_RD_RSVD2;
      cond_view[`ISSM_BIT_CMRST] = cm_reset;
      cond_view[`ISSM_BIT_RSVD0] = `ISSM_RD_RSVD0;
      mode_view = 8'h00;
      mode_view[`ISSM_BIT_MST] = mode[1];
      mode_view[`ISSM_BIT_TRS] = mode[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ISSM_RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_fire) begin
            s_axi_rdata <= rd_cond ? {24'h000000, cond_view} :
               rd_mode ? {24'h000000, mode_view} : 32'h00000000;
            s_axi_rresp <= (rd_cond | rd_mode) ? `ISSM_RESP_OKAY :
               `ISSM_RESP_SLVERR;
         end
      end
   end

   // ------------------------------------------------------------------
   // Condition generator
   // ------------------------------------------------------------------
   issm_cond_gen #(
      .T_CYC(T_COND_CYC)
   ) u_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .cif(cif)
   );

endmodule : issm_ctrl

`default_nettype wire

// File: issm_defs.svh
// Constants for the start/stop condition and line monitor block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
`ifndef ISSM_DEFS_SVH
`define ISSM_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ISSM_OFF_COND 12'h000
`define ISSM_OFF_MODE 12'h004

// ----------------------------------------------------------------------
// bus_condition_control fields
// ----------------------------------------------------------------------
`define ISSM_BIT_BUSY 7
`define ISSM_BIT_ISSUE 6
`define ISSM_BIT_SDAMON 5
`define ISSM_BIT_RSVD4 4
`define ISSM_BIT_SCLMON 3
`define ISSM_BIT_RSVD2 2
`define ISSM_BIT_CMRST 1
`define ISSM_BIT_RSVD0 0
`define ISSM_RST_RSVD4 1'h1
`define ISSM_RST_CMRST 1'h0
`define ISSM_RD_ISSUE 1'h1
`define ISSM_RD_RSVD2 1'h0
`define ISSM_RD_RSVD0 1'h1

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define ISSM_BIT_MST 5
`define ISSM_BIT_TRS 4
`define ISSM_RST_MODE 2'h0

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define ISSM_RESP_OKAY 2'h0
`define ISSM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ISSM_CLK_PERIOD_NS 10
`define ISSM_T_COND_NS 4700
`define ISSM_T_COND_CYC \
   ((`ISSM_T_COND_NS + `ISSM_CLK_PERIOD_NS - 1) / `ISSM_CLK_PERIOD_NS)

`endif

// File: issm_monitor.sv
// Checker for issm_ctrl: bus answers, fixed bits and line sequences.
// Assumes it is bound to issm_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module issm_monitor #(
   parameter int T_COND_CYC = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // Bus lines
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic scl_out,
   input wire logic scl_oe
);
   // Five condition times, more than the three of a start sequence, plus the register round trip
   localparam int LIM = 5 * T_COND_CYC + 20;
   logic [11:0] rd_addr;
   logic [15:0] wr_age;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire rd_cond = rd_addr == 12'h000;
   wire rd_bad = rd_addr != 12'h000 && rd_addr != 12'h004;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr <= 12'h000;
         wr_age <= 16'hffff;
      end else begin
         if (ar_take) rd_addr <= s_axi_araddr;
         if (aw_take) wr_age <= 16'h0000;
         else if (wr_age != 16'hffff) wr_age <= wr_age + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Both halves land together, the write is done one edge later and
   // the answer shows the edge after that
   a_wr_answer: assert property (aw_take && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("no write answer");
   a_rd_answer: assert property (ar_take |=> s_axi_rvalid)
      else $error("no read answer");
   a_unmapped_read: assert property (s_axi_rvalid && rd_bad
      |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_issue_reads_one: assert property (
      s_axi_rvalid && rd_cond |-> s_axi_rdata[6] && !s_axi_rdata[2]
      && s_axi_rdata[0] && s_axi_rdata[31:8] == 24'h0)
      else $error("fixed bits of condition register wrong");
   a_sda_monitor: assert property (
      s_axi_rvalid && rd_cond && $stable(sda_oe)
      |-> s_axi_rdata[5] == !sda_oe) else $error("data monitor wrong");
   a_scl_monitor: assert property (
      s_axi_rvalid && rd_cond && $stable(scl_oe)
      |-> s_axi_rdata[3] == !scl_oe) else $error("clock monitor wrong");
   a_start_order: assert property (
      $rose(sda_oe) && !scl_oe |-> ##[1:LIM] $rose(scl_oe))
      else $error("start without clock pull");
   a_stop_setup: assert property (
      $fell(scl_oe) && sda_oe |-> sda_oe [*3])
      else $error("data released too soon in stop");
   a_no_spontaneous: assert property (
      $rose(sda_oe) || $rose(scl_oe) |-> wr_age < LIM)
      else $error("line pulled without a write");
   a_open_drain: assert property (!sda_out && !scl_out)
      else $error("line driven high");

   c_start: cover property ($rose(scl_oe) && sda_oe);
   c_stop: cover property ($fell(sda_oe) && !scl_oe);
   c_unmapped: cover property (s_axi_rvalid && rd_bad);
endmodule : issm_monitor

bind issm_ctrl issm_monitor #(.T_COND_CYC(T_COND_CYC)) i_issm_monitor (.*);

`default_nettype wire

// File: issm_pkg.sv
// Types for the start/stop condition and line monitor block.
// Assumes issm_defs.svh holds every number.
package issm_pkg;

   // Condition generator sequence
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_S_REL_SDA = 3'h1,
      ST_S_REL_SCL = 3'h2,
      ST_S_SDA_LOW = 3'h3,
      ST_S_SCL_LOW = 3'h4,
      ST_P_SDA_LOW = 3'h5,
      ST_P_REL_SCL = 3'h6,
      ST_P_REL_SDA = 3'h7
   } issm_gen_state_t;

   // Operating mode, master_select then transmit_select
   typedef enum logic [1:0] {
      MODE_SLV_RX = 2'h0,
      MODE_SLV_TX = 2'h1,
      MODE_MST_RX = 2'h2,
      MODE_MST_TX = 2'h3
   } issm_mode_t;

endpackage : issm_pkg

// File: tb.sv
// Self-checking bench for issm_ctrl against a two-wire bus peer.
// Assumes the design, issm_bus_peer and issm_monitor compile first.
`timescale 1ns/1ps
`default_nettype none
`include "issm_defs.svh"

module tb;
   logic aclk, aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic sda_in, sda_out, sda_oe, scl_in, scl_out, scl_oe;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;

   issm_ctrl #(.T_COND_CYC(4)) i_issm_ctrl (.*);
   issm_bus_peer i_issm_bus_peer (.sda_oe(sda_oe), .scl_oe(scl_oe),
      .sda(sda_in), .scl(scl_in));

   // ---------------------------------------------------------------
   // Bus cycles and comparison
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] er = 2'h0);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rchk(input logic [11:0] a, input logic [7:0] e,
      input string what);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, d, {24'h0, e});
   endtask : rchk

   // Both enables must keep the expected levels for 40 cycles
   task automatic hold(input logic [1:0] e, input string what);
      logic [1:0] s;
      s = e;
      repeat (40) begin
         @(posedge aclk);
         if ({sda_oe, scl_oe} !== e) s = {sda_oe, scl_oe};
      end
      chk(what, {30'h0, s}, {30'h0, e});
   endtask : hold

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rchk(`ISSM_OFF_COND, 8'h79, "cond at reset");
      rchk(`ISSM_OFF_MODE, 8'h00, "mode at reset");
      rd(12'h008, d, r);
      chk("unmapped resp", {30'h0, r}, 32'h2);
      chk("unmapped data", d, 32'h0);
      // Lane 0 off: the write is answered but changes nothing
      s_axi_wstrb <= 4'he;
      wr(`ISSM_OFF_MODE, 8'h30);
      s_axi_wstrb <= 4'hf;
      rchk(`ISSM_OFF_MODE, 8'h00, "mode after lane 0 off");
      wr(12'h008, 8'h00, 2'h2);
      $display("reset test done");
   endtask : t_reset

   task automatic t_peer;
      i_issm_bus_peer.start();
      repeat (5) @(posedge aclk);
      rchk(`ISSM_OFF_COND, 8'hf9, "busy after peer start");
      i_issm_bus_peer.stop();
      repeat (5) @(posedge aclk);
      rchk(`ISSM_OFF_COND, 8'h79, "busy after peer stop");
      $display("peer test done");
   endtask : t_peer

   task automatic t_gate;
      for (int m = 0; m < 2; m++) begin
         wr(`ISSM_OFF_MODE, {3'h0, m[0], 4'h0});
         wr(`ISSM_OFF_COND, 8'h90);
         hold(2'h0, "slave start ignored");
         wr(`ISSM_OFF_COND, 8'h10);
         rchk(`ISSM_OFF_COND, 8'h79, "monitors kept in slave");
      end
      $display("slave gate test done");
   endtask : t_gate

   task automatic t_master;
      wr(`ISSM_OFF_MODE, 8'h30);
      wr(`ISSM_OFF_COND, 8'h90);
      wait (scl_oe === 1'b1);
      wr(`ISSM_OFF_COND, 8'h50);
      hold(2'h3, "write of issue 1 ignored");
      rchk(`ISSM_OFF_COND, 8'hd1, "cond after start");
      wr(`ISSM_OFF_MODE, 8'h20);
      wr(`ISSM_OFF_COND, 8'h90);
      wait (scl_oe === 1'b0);
      wait (scl_oe === 1'b1);
      repeat (5) @(posedge aclk);
      rchk(`ISSM_OFF_COND, 8'hd1, "cond after restart");
      wr(`ISSM_OFF_COND, 8'h10);
      wait (sda_oe === 1'b0);
      repeat (5) @(posedge aclk);
      rchk(`ISSM_OFF_COND, 8'h79, "cond after stop");
      hold(2'h0, "lines free after stop");
      $display("master test done");
   endtask : t_master

   task automatic t_cmrst;
      wr(`ISSM_OFF_COND, 8'h90);
      wait (scl_oe === 1'b1);
      wr(`ISSM_OFF_COND, 8'hd2);
      wait (sda_oe === 1'b0 && scl_oe === 1'b0);
      hold(2'h0, "lines freed by module reset");
      rchk(`ISSM_OFF_COND, 8'h7b, "cond in module reset");
      rchk(`ISSM_OFF_MODE, 8'h20, "mode kept");
      wr(`ISSM_OFF_COND, 8'h92);
      hold(2'h0, "start refused in module reset");
      wr(`ISSM_OFF_COND, 8'hd0);
      rchk(`ISSM_OFF_COND, 8'h79, "cond after module reset");
      $display("module reset test done");
   endtask : t_cmrst

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // A hang ends the run as a mismatch
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_peer();
      t_gate();
      t_master();
      t_cmrst();
      final_report();
   end
endmodule : tb

`default_nettype wire
